// ### logic/rls_pkg.sv
package rls_pkg;
	// bank geometry
	localparam int AUX_BITS = 63;
	localparam int NUM_TMR = 31;
	localparam int NUM_CNT = 31;
	localparam int VAL_W = 16;
	localparam int DIN_BITS = 12;
	localparam int KEY_BITS = 4;
	localparam int DOUT_BITS = 8;
	localparam int TEMP_CH = 4;
	localparam int SER_FLAGS = 3;

	// special bit positions in the retained bank (bit 0 is the first aux bit)
	localparam int BIT_FIRST_SCAN = 48;
	localparam int BIT_BLINK = 49;
	localparam int BIT_DST = 50;
	localparam int BIT_TEMP_ERR = 51;
	localparam int BIT_RSVD_LO = 55;
	localparam int BIT_RSVD_HI = 59;
	localparam int BIT_SERIAL = 60;

	// input and output counts per model
	localparam logic [11:0] DIN_MASK_6 = 12'h03F;
	localparam logic [11:0] DIN_MASK_8 = 12'h0FF;
	localparam logic [11:0] DIN_MASK_12 = 12'hFFF;
	localparam logic [7:0] DOUT_MASK_4 = 8'h0F;
	localparam logic [7:0] DOUT_MASK_8 = 8'hFF;

	// timing: figures in ns, cycles derived from the core clock period
	localparam longint CLK_PERIOD_NS = 10;
	localparam longint TMR_UNIT_NS = 10_000_000;
	localparam longint BLINK_HALF_NS = 500_000_000;
	localparam int TMR_UNIT_CYC = int'(TMR_UNIT_NS / CLK_PERIOD_NS);
	localparam int BLINK_HALF_CYC = int'(BLINK_HALF_NS / CLK_PERIOD_NS);

	// daylight-saving rule sets
	typedef enum logic [1:0] {DST_NONE, DST_EUROPE, DST_USA, DST_USER} rls_dst_e;
	localparam logic [3:0] EU_SUM_MONTH = 4'h3;
	localparam logic [2:0] EU_SUM_NTH = 3'h0;
	localparam logic [3:0] EU_WIN_MONTH = 4'hA;
	localparam logic [2:0] EU_WIN_NTH = 3'h0;
	localparam logic [4:0] EU_HOUR = 5'h01;
	localparam logic [3:0] US_SUM_MONTH = 4'h3;
	localparam logic [2:0] US_SUM_NTH = 3'h2;
	localparam logic [3:0] US_WIN_MONTH = 4'hB;
	localparam logic [2:0] US_WIN_NTH = 3'h1;
	localparam logic [4:0] US_HOUR = 5'h02;
	localparam logic [4:0] USER_HOUR_MIN = 5'h01;
	localparam logic [4:0] USER_HOUR_MAX = 5'h16;
	localparam logic [2:0] NTH_LAST = 3'h0;
endpackage

// ### logic/rls_status.sv
// Summary of operation
// - first-scan bit on in first scan only
// - blink bit half second on, half off
// - daylight bit on in summer, off winter
// - four temperature channel error bits
// - five reserved bits, three serial status bits
// - retained bank survives power loss when enabled
// - second bank same size, no status bits, never retained
// - 63 bits per bank, 31 timers, 31 counters
// - 6, 8 or 12 inputs plus 4 keys
// - 4 or 8 outputs by model
// - aux bits readable and writable, no pins
// - timer status on when value reaches preset
// - dropping timer enable resets the timer
// - counter status on when value reaches preset
// - count changes once per rising count input
// - counter reset input clears the counter
// - direction input on counts downward
// - Europe, USA and user daylight rule sets
// - user day value 0 means last Sunday
// - user changeover hour 1..22 for both changes
module rls_status
	import rls_pkg::*;
#(
	parameter int TMR_UNIT_CYCLES = TMR_UNIT_CYC,
	parameter int BLINK_HALF_CYCLES = BLINK_HALF_CYC
)
(
	input wire logic I_CORE_CLK,
	input wire logic I_RESET,
	input wire logic i_SCAN_STROBE,
	input wire logic i_POWER_LOSS,
	input wire logic i_RETAIN_EN,
	input wire logic [1:0] i_IN_MODEL,
	input wire logic i_OUT_MODEL,
	input wire logic i_KEYPAD_FITTED,
	input wire logic [DIN_BITS-1:0] i_DIN_PINS,
	input wire logic [KEY_BITS-1:0] i_KEY_PINS,
	input wire logic [DOUT_BITS-1:0] i_Q_COIL,
	input wire logic [AUX_BITS-1:0] i_M_WR_EN,
	input wire logic [AUX_BITS-1:0] i_M_WR_DATA,
	input wire logic [AUX_BITS-1:0] i_N_WR_EN,
	input wire logic [AUX_BITS-1:0] i_N_WR_DATA,
	input wire logic [NUM_TMR-1:0] i_TMR_EN,
	input wire logic [NUM_TMR-1:0][VAL_W-1:0] i_TMR_PRESET,
	input wire logic [NUM_CNT-1:0] i_CNT_IN,
	input wire logic [NUM_CNT-1:0] i_CNT_RST,
	input wire logic [NUM_CNT-1:0] i_CNT_DOWN,
	input wire logic [NUM_CNT-1:0][VAL_W-1:0] i_CNT_PRESET,
	input wire logic [TEMP_CH-1:0] i_TEMP_ERR,
	input wire logic [SER_FLAGS-1:0] i_SER_EVENT,
	input wire logic [1:0] i_DST_RULE,
	input wire logic [3:0] i_DST_SUM_MONTH,
	input wire logic [2:0] i_DST_SUM_DAY,
	input wire logic [3:0] i_DST_WIN_MONTH,
	input wire logic [2:0] i_DST_WIN_DAY,
	input wire logic [4:0] i_DST_HOUR,
	input wire logic [6:0] i_RTC_YEAR,
	input wire logic [3:0] i_RTC_MONTH,
	input wire logic [4:0] i_RTC_DAY,
	input wire logic [2:0] i_RTC_WDAY,
	input wire logic [4:0] i_RTC_HOUR,
	output logic [AUX_BITS-1:0] o_M_BANK,
	output logic [AUX_BITS-1:0] o_N_BANK,
	output logic [DIN_BITS-1:0] o_DIN_IMAGE,
	output logic [KEY_BITS-1:0] o_KEY_IMAGE,
	output logic [DOUT_BITS-1:0] o_Q_PINS,
	output logic [NUM_TMR-1:0] o_TMR_STATUS,
	output logic [NUM_TMR-1:0][VAL_W-1:0] o_TMR_VALUE,
	output logic [NUM_CNT-1:0] o_CNT_STATUS,
	output logic [NUM_CNT-1:0][VAL_W-1:0] o_CNT_VALUE
);

	////////////////////////////////////////////////////////////////////////////
	// state
	typedef struct packed {
		logic [AUX_BITS-1:0] m_bank; // retained bank
		logic [AUX_BITS-1:0] n_bank; // volatile bank
		logic [DIN_BITS-1:0] din_meta; // first sync stage, read by second only
		logic [DIN_BITS-1:0] din_sync;
		logic [KEY_BITS-1:0] key_meta;
		logic [KEY_BITS-1:0] key_sync;
		logic [DIN_BITS-1:0] din_img; // input image frozen per scan
		logic [KEY_BITS-1:0] key_img;
		logic [DOUT_BITS-1:0] q_out;
		logic [NUM_TMR-1:0][VAL_W-1:0] tmr_cur;
		logic [NUM_TMR-1:0] tmr_stat;
		logic [NUM_CNT-1:0][VAL_W-1:0] cnt_cur;
		logic [NUM_CNT-1:0] cnt_prev; // count input as seen last scan
		logic [NUM_CNT-1:0] cnt_stat;
		logic [SER_FLAGS-1:0] ser_pend; // serial events waiting for a scan
		logic first_pend; // next scan is the first one
		logic first_live; // the first scan has just run
		logic [31:0] tick_cnt;
		logic tick_pend; // a timer unit elapsed since the last scan
		logic [31:0] blink_cnt;
		logic blink;
	} rls_state_s;

	rls_state_s st_q; // registered state
	rls_state_s st_d; // next state

	////////////////////////////////////////////////////////////////////////////
	// helpers

	// days in the current month
	// leap years taken as every fourth year; the two-digit year never hits a century
	function automatic logic [4:0] rls_mlen(input logic [3:0] mon, input logic [6:0] yr);
		logic [4:0] len;
		len = 5'h1F;
		case (mon)
			4'h2: len = (yr[1:0] == 2'h0) ? 5'h1D : 5'h1C;
			4'h4, 4'h6, 4'h9, 4'hB: len = 5'h1E;
			default: len = 5'h1F;
		endcase
		return len;
	endfunction

	// date of the nth Sunday of this month; nth of zero picks the last one
	// first Sunday found by stepping back from today by the weekday
	function automatic logic [5:0] rls_sunday(input logic [4:0] day, input logic [2:0] wday,
		input logic [4:0] mlen, input logic [2:0] nth);
		logic [5:0] first;
		logic [5:0] span;
		first = 6'(((6'(day) + 6'h06 - 6'(wday)) % 6'h07) + 6'h01);
		span = 6'(mlen) - first;
		if (nth == NTH_LAST)
			return 6'(first + 6'h07 * (span / 6'h07));
		else
			return 6'(first + 6'h07 * (6'(nth) - 6'h01));
	endfunction

	// true once the changeover moment of the given month has been reached
	// months before the target month compare false, later ones true
	function automatic logic rls_past(input logic [3:0] tmon, input logic [2:0] nth,
		input logic [4:0] hr);
		logic [5:0] tday;
		tday = rls_sunday(i_RTC_DAY, i_RTC_WDAY, rls_mlen(i_RTC_MONTH, i_RTC_YEAR), nth);
		if (i_RTC_MONTH != tmon)
			return i_RTC_MONTH > tmon;
		else if (6'(i_RTC_DAY) != tday)
			return 6'(i_RTC_DAY) > tday;
		else
			return i_RTC_HOUR >= hr;
	endfunction

	// active input mask for the fitted model
	function automatic logic [DIN_BITS-1:0] rls_din_mask(input logic [1:0] model);
		case (model)
			2'h0: return DIN_MASK_6;
			2'h1: return DIN_MASK_8;
			default: return DIN_MASK_12;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// daylight-saving decision, from the live calendar
	logic [4:0] user_hour; // user hour clamped into its legal window
	logic dst_on; // summer time is in effect
	logic dst_active; // a rule set is selected at all

	// out-of-range user hours are clamped rather than ignored, so the bit never sticks
	// both transitions use the same hour in the user rule
	always_comb
	begin
		if (i_DST_HOUR < USER_HOUR_MIN)
			user_hour = USER_HOUR_MIN;
		else if (i_DST_HOUR > USER_HOUR_MAX)
			user_hour = USER_HOUR_MAX;
		else
			user_hour = i_DST_HOUR;
		dst_active = 1'b1;
		case (rls_dst_e'(i_DST_RULE))
			DST_EUROPE: dst_on = rls_past(EU_SUM_MONTH, EU_SUM_NTH, EU_HOUR)
				&& !rls_past(EU_WIN_MONTH, EU_WIN_NTH, EU_HOUR);
			DST_USA: dst_on = rls_past(US_SUM_MONTH, US_SUM_NTH, US_HOUR)
				&& !rls_past(US_WIN_MONTH, US_WIN_NTH, US_HOUR);
			DST_USER: dst_on = rls_past(i_DST_SUM_MONTH, i_DST_SUM_DAY, user_hour)
				&& !rls_past(i_DST_WIN_MONTH, i_DST_WIN_DAY, user_hour);
			default:
			begin
				dst_on = 1'b0;
				dst_active = 1'b0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// next-state logic
	always_comb
	begin
		st_d = st_q;

		// pins pass two flops before anything looks at them
		st_d.din_meta = i_DIN_PINS;
		st_d.din_sync = st_q.din_meta;
		st_d.key_meta = i_KEY_PINS;
		st_d.key_sync = st_q.key_meta;

		// timer unit base runs free between scans; one pending unit is kept
		// only one unit is banked, so a late scan loses time rather than bursting
		if (st_q.tick_cnt >= 32'(TMR_UNIT_CYCLES - 1))
		begin
			st_d.tick_cnt = 32'h0000_0000;
			st_d.tick_pend = 1'b1;
		end
		else
			st_d.tick_cnt = st_q.tick_cnt + 32'h0000_0001;

		// blink base toggles every half period
		// the bit is sampled at scans, so scan jitter shows up as blink jitter
		if (st_q.blink_cnt >= 32'(BLINK_HALF_CYCLES - 1))
		begin
			st_d.blink_cnt = 32'h0000_0000;
			st_d.blink = ~st_q.blink;
		end
		else
			st_d.blink_cnt = st_q.blink_cnt + 32'h0000_0001;

		// serial events are held until the next scan picks them up
		// an event arriving between scans must not be lost, hence the pending bits
		st_d.ser_pend = st_q.ser_pend | i_SER_EVENT;

		if (i_SCAN_STROBE)
		begin
			// program coil writes to both banks, no pin behind them
			st_d.m_bank = (st_q.m_bank & ~i_M_WR_EN) | (i_M_WR_DATA & i_M_WR_EN);
			st_d.n_bank = (st_q.n_bank & ~i_N_WR_EN) | (i_N_WR_DATA & i_N_WR_EN);

			// the scan after the first one hands the bit back to the program;
			// without this the forced value would linger as a stale program state
			if (st_q.first_live)
			begin
				st_d.m_bank[BIT_FIRST_SCAN] = i_M_WR_EN[BIT_FIRST_SCAN]
					& i_M_WR_DATA[BIT_FIRST_SCAN];
				st_d.first_live = 1'b0;
			end

			// first scan forces the flag, later scans leave the program value
			if (st_q.first_pend)
			begin
				st_d.m_bank[BIT_FIRST_SCAN] = 1'b1;
				st_d.first_pend = 1'b0;
				st_d.first_live = 1'b1;
			end

			st_d.m_bank[BIT_BLINK] = st_q.blink;

			// with no rule selected the bit is left to the program
			if (dst_active)
				st_d.m_bank[BIT_DST] = dst_on;

			st_d.m_bank[BIT_TEMP_ERR +: TEMP_CH] = i_TEMP_ERR;
			st_d.m_bank[BIT_RSVD_HI:BIT_RSVD_LO] = '0;

			// a pending event beats a clear written in the same scan
			st_d.m_bank[BIT_SERIAL +: SER_FLAGS] = st_d.m_bank[BIT_SERIAL +: SER_FLAGS]
				| st_q.ser_pend | i_SER_EVENT;
			st_d.ser_pend = '0;

			// field images sized to the fitted model
			// unfitted positions read as zero so a program cannot see floating pins
			st_d.din_img = st_q.din_sync & rls_din_mask(i_IN_MODEL);
			st_d.key_img = i_KEYPAD_FITTED ? st_q.key_sync : '0;
			st_d.q_out = i_Q_COIL & (i_OUT_MODEL ? DOUT_MASK_8 : DOUT_MASK_4);

			// timers: on-delay, stop at preset, clear when disabled
			for (int t = 0; t < NUM_TMR; t++)
			begin
				if (!i_TMR_EN[t])
					st_d.tmr_cur[t] = '0;
				else if (st_q.tick_pend && st_q.tmr_cur[t] < i_TMR_PRESET[t])
					st_d.tmr_cur[t] = st_q.tmr_cur[t] + 16'h0001;
				// status from the new value so it matches the value shown
				st_d.tmr_stat[t] = st_d.tmr_cur[t] >= i_TMR_PRESET[t];
			end
			// a unit that lands on the scan cycle itself is not dropped
			st_d.tick_pend = (st_q.tick_cnt >= 32'(TMR_UNIT_CYCLES - 1));

			// counters: edge counting, reset wins, saturating both ways
			// saturation avoids a wrap that would flip the status bit unexpectedly
			for (int c = 0; c < NUM_CNT; c++)
			begin
				st_d.cnt_prev[c] = i_CNT_IN[c];
				if (i_CNT_RST[c])
					st_d.cnt_cur[c] = '0;
				else if (i_CNT_IN[c] && !st_q.cnt_prev[c])
				begin
					if (i_CNT_DOWN[c])
					begin
						if (st_q.cnt_cur[c] != '0)
							st_d.cnt_cur[c] = st_q.cnt_cur[c] - 16'h0001;
					end
					else if (st_q.cnt_cur[c] != '1)
						st_d.cnt_cur[c] = st_q.cnt_cur[c] + 16'h0001;
				end
				st_d.cnt_stat[c] = st_d.cnt_cur[c] >= i_CNT_PRESET[c];
			end
		end

		// power loss: volatile state goes, retained bank stays if enabled
		// applied after the scan logic so a coincident scan cannot undo it
		if (i_POWER_LOSS)
		begin
			if (!i_RETAIN_EN)
				st_d.m_bank = '0;
			st_d.n_bank = '0;
			st_d.tmr_cur = '0;
			st_d.tmr_stat = '0;
			st_d.cnt_cur = '0;
			st_d.cnt_stat = '0;
			st_d.q_out = '0;
			st_d.first_pend = 1'b1;
			st_d.first_live = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// state register; program image updates happen on scan strobes, or on power loss
	// reset arms the first scan; every other flop starts at zero
	always_ff @(posedge I_CORE_CLK or posedge I_RESET)
	begin
		if (I_RESET)
		begin
			st_q <= '0;
			st_q.first_pend <= 1'b1;
		end
		else
			st_q <= st_d;
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs straight from the state flops
	// no logic between the flops and the pins keeps output timing clean
	assign o_M_BANK = st_q.m_bank;
	assign o_N_BANK = st_q.n_bank;
	assign o_DIN_IMAGE = st_q.din_img;
	assign o_KEY_IMAGE = st_q.key_img;
	assign o_Q_PINS = st_q.q_out;
	assign o_TMR_STATUS = st_q.tmr_stat;
	assign o_TMR_VALUE = st_q.tmr_cur;
	assign o_CNT_STATUS = st_q.cnt_stat;
	assign o_CNT_VALUE = st_q.cnt_cur;

endmodule

// ### verification/rls_field.sv
module rls_field
	import rls_pkg::*;
(
	input wire logic clk,
	input wire logic [DIN_BITS-1:0] i_sw,
	input wire logic [KEY_BITS-1:0] i_key,
	output logic [DIN_BITS-1:0] o_din,
	output logic [KEY_BITS-1:0] o_keys
);
	// switches are wired at power-up, all open
	initial
	begin
		o_din = '0;
		o_keys = '0;
	end
	// field levels move on the falling edge, clear of the sampling edge
	always @(negedge clk)
	begin
		o_din <= i_sw;
		o_keys <= i_key;
	end
endmodule

// ### verification/rls_status_assertions.sv
module rls_chk
	import rls_pkg::*;
(
	input wire logic I_CORE_CLK,
	input wire logic I_RESET,
	input wire logic i_SCAN_STROBE,
	input wire logic i_POWER_LOSS,
	input wire logic i_RETAIN_EN,
	input wire logic i_OUT_MODEL,
	input wire logic [TEMP_CH-1:0] i_TEMP_ERR,
	input wire logic [NUM_CNT-1:0] i_CNT_RST,
	input wire logic [NUM_CNT-1:0][VAL_W-1:0] i_CNT_PRESET,
	input wire logic [NUM_TMR-1:0][VAL_W-1:0] i_TMR_PRESET,
	input wire logic [AUX_BITS-1:0] o_M_BANK,
	input wire logic [AUX_BITS-1:0] o_N_BANK,
	input wire logic [DOUT_BITS-1:0] o_Q_PINS,
	input wire logic [NUM_TMR-1:0] o_TMR_STATUS,
	input wire logic [NUM_TMR-1:0][VAL_W-1:0] o_TMR_VALUE,
	input wire logic [NUM_CNT-1:0] o_CNT_STATUS,
	input wire logic [NUM_CNT-1:0][VAL_W-1:0] o_CNT_VALUE
);
	default clocking @(posedge I_CORE_CLK); endclocking
	default disable iff (I_RESET);
	// a scan that is not overridden by a power-loss pulse
	sequence scan_s;
		i_SCAN_STROBE && !i_POWER_LOSS;
	endsequence
	rsvd_zero_a: assert property (scan_s |=> o_M_BANK[59:55] == 5'h00)
		else $error("reserved bits not clear");
	temp_follow_a: assert property (scan_s |=> o_M_BANK[54:51] == $past(i_TEMP_ERR))
		else $error("temperature flags wrong");
	tmr_cmp_a: assert property (scan_s |=> o_TMR_STATUS[0] == (o_TMR_VALUE[0] >= $past(i_TMR_PRESET[0])))
		else $error("timer status wrong");
	cnt_cmp_a: assert property (scan_s |=> o_CNT_STATUS[0] == (o_CNT_VALUE[0] >= $past(i_CNT_PRESET[0])))
		else $error("counter status wrong");
	cnt_clear_a: assert property ((scan_s ##0 i_CNT_RST[0]) |=> o_CNT_VALUE[0] == 16'h0000)
		else $error("counter not cleared");
	scan_hold_a: assert property (!i_SCAN_STROBE && !i_POWER_LOSS |=> $stable(o_CNT_VALUE) && $stable(o_N_BANK))
		else $error("state moved between scans");
	loss_clear_a: assert property (i_POWER_LOSS |=> o_N_BANK == '0 && o_Q_PINS == 8'h00)
		else $error("volatile state kept");
	retain_keep_a: assert property (i_POWER_LOSS && i_RETAIN_EN && !i_SCAN_STROBE |=> $stable(o_M_BANK))
		else $error("retained bank lost");
	q_mask_a: assert property ((scan_s ##0 !i_OUT_MODEL) |=> o_Q_PINS[7:4] == 4'h0)
		else $error("absent outputs driven");
endmodule
bind rls_status rls_chk i_chk (.I_CORE_CLK, .I_RESET, .i_SCAN_STROBE, .i_POWER_LOSS, .i_RETAIN_EN,
	.i_OUT_MODEL, .i_TEMP_ERR, .i_CNT_RST, .i_CNT_PRESET, .i_TMR_PRESET, .o_M_BANK, .o_N_BANK,
	.o_Q_PINS, .o_TMR_STATUS, .o_TMR_VALUE, .o_CNT_STATUS, .o_CNT_VALUE);

// ### verification/rls_status_tb_top.sv
module rls_status_tb_top
	import rls_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic I_CORE_CLK = 0, I_RESET = 1, i_SCAN_STROBE = 0, i_POWER_LOSS = 0, i_RETAIN_EN = 0;
	logic i_OUT_MODEL = 1, i_KEYPAD_FITTED = 0;
	logic [1:0] i_IN_MODEL = 2, i_DST_RULE = 0;
	logic [DIN_BITS-1:0] i_DIN_PINS, sw = '0;
	logic [KEY_BITS-1:0] i_KEY_PINS, keys = '0;
	logic [DOUT_BITS-1:0] i_Q_COIL = '0;
	logic [AUX_BITS-1:0] i_M_WR_EN = '0, i_M_WR_DATA = '0, i_N_WR_EN = '0, i_N_WR_DATA = '0;
	logic [NUM_TMR-1:0] i_TMR_EN = '0;
	logic [NUM_TMR-1:0][VAL_W-1:0] i_TMR_PRESET = '0;
	logic [NUM_CNT-1:0] i_CNT_IN = '0, i_CNT_RST = '0, i_CNT_DOWN = '0;
	logic [NUM_CNT-1:0][VAL_W-1:0] i_CNT_PRESET = '0;
	logic [TEMP_CH-1:0] i_TEMP_ERR = '0;
	logic [SER_FLAGS-1:0] i_SER_EVENT = '0;
	logic [3:0] i_DST_SUM_MONTH = 4'h5, i_DST_WIN_MONTH = 4'hA, i_RTC_MONTH = 4'h1;
	logic [2:0] i_DST_SUM_DAY = 3'h1, i_DST_WIN_DAY = 3'h0, i_RTC_WDAY = '0;
	logic [4:0] i_DST_HOUR = 5'h01, i_RTC_DAY = 5'h01, i_RTC_HOUR = '0;
	logic [6:0] i_RTC_YEAR = 7'h09;
	logic [AUX_BITS-1:0] o_M_BANK, o_N_BANK;
	logic [DIN_BITS-1:0] o_DIN_IMAGE;
	logic [KEY_BITS-1:0] o_KEY_IMAGE;
	logic [DOUT_BITS-1:0] o_Q_PINS;
	logic [NUM_TMR-1:0] o_TMR_STATUS;
	logic [NUM_TMR-1:0][VAL_W-1:0] o_TMR_VALUE;
	logic [NUM_CNT-1:0] o_CNT_STATUS;
	logic [NUM_CNT-1:0][VAL_W-1:0] o_CNT_VALUE;
	int bad_count = 0, checked = 0, cycles = 0;
	// short timer unit and blink half period keep the run brief
	rls_status #(.TMR_UNIT_CYCLES(10), .BLINK_HALF_CYCLES(8)) i_dut (.*);
	rls_field i_field (.clk(I_CORE_CLK), .i_sw(sw), .i_key(keys), .o_din(i_DIN_PINS),
		.o_keys(i_KEY_PINS));
	always #5 I_CORE_CLK = ~I_CORE_CLK;
	////////////////////////////////////////////////////////////////
	task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
		checked++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task summarize();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// hang guard, far above the fewer than two hundred cycles needed
	always @(posedge I_CORE_CLK)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			bad_count++;
			summarize();
		end
	end
	task step();
		@(negedge I_CORE_CLK);
	endtask
	task scan();
		step();
		i_SCAN_STROBE = 1;
		step();
		i_SCAN_STROBE = 0;
	endtask
	task ploss();
		step();
		i_POWER_LOSS = 1;
		step();
		i_POWER_LOSS = 0;
	endtask
	////////////////////////////////////////////////////////////////
	task t_first_aux();
		i_M_WR_EN[5] = 1; i_M_WR_DATA[5] = 1; i_N_WR_EN[7] = 1; i_N_WR_DATA[7] = 1;
		scan();
		chk("first", o_M_BANK[BIT_FIRST_SCAN], 1);
		chk("m5", o_M_BANK[5], 1);
		chk("n7", o_N_BANK[7], 1);
		i_M_WR_EN = '0; i_N_WR_EN = '0; i_RETAIN_EN = 1;
		scan();
		chk("first2", o_M_BANK[BIT_FIRST_SCAN], 0);
		ploss();
		chk("keep", o_M_BANK[5], 1);
		chk("nlost", o_N_BANK, 0);
		scan();
		chk("rearm", o_M_BANK[BIT_FIRST_SCAN], 1);
		i_RETAIN_EN = 0;
		ploss();
		chk("mlost", o_M_BANK[5], 0);
		$display("t_first_aux done");
	endtask
	task t_cnt();
		i_CNT_PRESET[0] = 16'h0002;
		// count input per scan 1,1,0,1 gives 1,1,1,2: steady high is ignored
		for (int k = 0; k < 4; k++)
		begin
			i_CNT_IN[0] = k != 2;
			scan();
			chk("cnt", o_CNT_VALUE[0], (k == 3) ? 2 : 1);
		end
		chk("cst", o_CNT_STATUS[0], 1);
		i_CNT_DOWN[0] = 1; i_CNT_IN[0] = 0;
		scan();
		i_CNT_IN[0] = 1;
		scan();
		chk("down", o_CNT_VALUE[0], 1);
		chk("cst2", o_CNT_STATUS[0], 0);
		i_CNT_RST[0] = 1;
		scan();
		chk("crst", o_CNT_VALUE[0], 0);
		i_CNT_RST[0] = 0;
		$display("t_cnt done");
	endtask
	task t_tmr();
		i_TMR_PRESET[0] = 16'h0003; i_TMR_EN[0] = 1;
		for (int k = 1; k < 5; k++)
		begin
			repeat (11) step();
			scan();
			chk("tval", o_TMR_VALUE[0], (k > 3) ? 3 : k);
			chk("tst", o_TMR_STATUS[0], k >= 3);
		end
		i_TMR_EN[0] = 0;
		scan();
		chk("toff", {o_TMR_STATUS[0], o_TMR_VALUE[0]}, 0);
		$display("t_tmr done");
	endtask
	task t_flags_io();
		i_TEMP_ERR = 4'hA; sw = 12'hFFF; keys = 4'hF; i_KEYPAD_FITTED = 1; i_Q_COIL = 8'hFF;
		i_IN_MODEL = 0; i_OUT_MODEL = 0;
		step();
		i_SER_EVENT = 3'h2;
		step();
		i_SER_EVENT = 3'h0;
		repeat (3) step();
		scan();
		chk("temp", o_M_BANK[54:51], 4'hA);
		chk("ser", o_M_BANK[62:55], 8'h40);
		chk("din6", o_DIN_IMAGE, 12'h03F);
		chk("keys", o_KEY_IMAGE, 4'hF);
		chk("q4", o_Q_PINS, 8'h0F);
		i_IN_MODEL = 2; i_OUT_MODEL = 1; i_M_WR_EN[61] = 1; i_M_WR_DATA[61] = 0;
		scan();
		chk("serclr", o_M_BANK[61], 0);
		chk("din12", o_DIN_IMAGE, 12'hFFF);
		chk("q8", o_Q_PINS, 8'hFF);
		i_M_WR_EN = '0;
		$display("t_flags_io done");
	endtask
	task t_blink();
		int n;
		n = 0;
		step();
		i_SCAN_STROBE = 1;
		// back-to-back scans over two full periods see the bit high half the time
		repeat (32)
		begin
			step();
			n += o_M_BANK[BIT_BLINK];
		end
		i_SCAN_STROBE = 0;
		chk("blink", n, 16);
		$display("t_blink done");
	endtask
	task t_dst();
		logic e;
		// rule, month, day, weekday, hour, summer expected; user rule May 1st Sun to Oct last Sun
		logic [19:0] tbl [7] = '{{2'h1, 4'h7, 5'h0F, 3'h3, 5'h0C, 1'b1},
			{2'h1, 4'h1, 5'h0F, 3'h4, 5'h0C, 1'b0}, {2'h2, 4'h7, 5'h04, 3'h6, 5'h0C, 1'b1},
			{2'h3, 4'h5, 5'h03, 3'h0, 5'h01, 1'b1}, {2'h3, 4'h5, 5'h02, 3'h6, 5'h0C, 1'b0},
			{2'h3, 4'hA, 5'h19, 3'h0, 5'h01, 1'b0}, {2'h3, 4'hA, 5'h18, 3'h6, 5'h0C, 1'b1}};
		for (int k = 0; k < 7; k++)
		begin
			{i_DST_RULE, i_RTC_MONTH, i_RTC_DAY, i_RTC_WDAY, i_RTC_HOUR, e} = tbl[k];
			scan();
			chk("dst", o_M_BANK[BIT_DST], e);
		end
		$display("t_dst done");
	endtask
	initial
	begin
		repeat (8) @(posedge I_CORE_CLK);
		step();
		I_RESET = 0;
		t_first_aux();
		t_cnt();
		t_tmr();
		t_flags_io();
		t_blink();
		t_dst();
		summarize();
	end
endmodule
